//--- include/dpr_pkg.sv
// Package for the deep power-down release controller.
// Assumes a 40 MHz system clock; the serial link is sampled by it.
package dpr_pkg;
  // ==========================================================
  // Commands and timing
  localparam logic [7:0] DEEP_SLEEP_ENTRY_CMD = 8'hB9;
  localparam logic [7:0] RELEASE_POWER_DOWN_CMD = 8'hAB;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SLEEP_ENTRY_DELAY_US = 3;
  localparam int STANDBY_RECOVERY_DELAY_US = 10;
  // Longest times round down to whole cycles
  localparam int SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int STANDBY_RECOVERY_CYC =
    (STANDBY_RECOVERY_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int DUMMY_CLOCKS = 3;
  localparam int ID_BITS = 24;
  localparam logic [ID_BITS-1:0] DEVICE_ID_RST = 24'h00_5A5A;
  localparam int CNT_W = 10;
  localparam int SAMPLE_STAGES = 2;
  typedef enum logic [1:0] {
    PWR_STANDBY, PWR_ENTERING, PWR_DEEP, PWR_WAKING
  } dpr_pwr_t;
endpackage

//--- hw/dpr_sync.sv
// Two-flop synchroniser bank for the link pins.
// Assumes inputs are asynchronous to clk; output is safe to read.
`timescale 1ns/1ps
module dpr_sync
  import dpr_pkg::*;
#(
  parameter int W = 4
)(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [W-1:0] d, // Asynchronous pins
  output logic [W-1:0] q // Synchronised copy
);
  // ==========================================================
  // Stages
  logic [W-1:0] s1_r;
  // First stage read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      q <= '0;
    end
    else
    begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule

//--- hw/dpr_ctrl.sv
// Deep power-down entry and release command logic of a serial flash.
// Assumes SCK at most a quarter of CLK_SYS; pins sampled by CLK_SYS.
// How it works
// - After entry command ends, lowest-power state within 3 us.
// - After release command ends, standby and ready within 10 us.
// - Release command leaves deep power-down, with or without ID read.
// - After dummy clocks device shifts ID out on SCK falling edges.
// - ID output continues until chip select rises; that starts wake-up.
// - Entry command B9H takes effect only when chip select rises.
// - In deep power-down every command except release is ignored.
// - Entry command is ignored while program or erase is busy.
`timescale 1ns/1ps
module dpr_ctrl
  import dpr_pkg::*;
(
  input wire logic CLK_SYS, // System clock, 40 MHz
  input wire logic RESETN, // Asynchronous reset, active low
  input wire logic CE_N, // Chip select, active low
  input wire logic SCK, // Serial clock from host
  input wire logic [3:0] SIO_IN, // Data lanes in
  output logic [3:0] SIO_OUT, // Data lanes out
  output logic [3:0] SIO_OE_N, // Lane drive enable, active low
  input wire logic QUAD_LANE_SERIAL_MODE, // Four-lane mode select
  input wire logic WRITE_BUSY, // Internal program or erase running
  output logic DEEP_SLEEP, // Lowest-power state reached
  output logic READY // Standby, accepting instructions
);
  import dpr_pkg::*;
  // ==========================================================
  // Reset release and pin sampling
  logic rst_n_s1_r, rst_n_r;
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_n_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_n_s1_r <= 1'b1;
      rst_n_r <= rst_n_s1_r;
    end
  end
  // Mode pin rides the same bank so it stays in step with chip select
  logic [6:0] pins_s;
  dpr_sync #(.W(7)) u_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .d({QUAD_LANE_SERIAL_MODE, ~CE_N, SCK, SIO_IN}),
    .q(pins_s)
  );
  logic cs_act, sck_s, cs_d_r, sck_d_r, quad_s;
  logic [3:0] sio_s;
  assign quad_s = pins_s[6];
  assign cs_act = pins_s[5];
  assign sck_s = pins_s[4];
  assign sio_s = pins_s[3:0];
  always_ff @(posedge CLK_SYS or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cs_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r <= cs_act;
      sck_d_r <= sck_s;
    end
  end
  logic sck_rise, sck_fall, cs_rise_end;
  assign sck_rise = cs_act && sck_s && !sck_d_r;
  assign sck_fall = cs_act && !sck_s && sck_d_r;
  assign cs_rise_end = cs_d_r && !cs_act; // Chip select went high
  // ==========================================================
  // Command shift register
  function automatic logic [7:0] shift_in(input logic [7:0] v,
    input logic [3:0] d, input logic quad);
    if (quad)
      shift_in = {v[3:0], d};
    else
      shift_in = {v[6:0], d[0]};
  endfunction
  logic [7:0] cmd_r;
  logic [3:0] bit_cnt_r;
  logic cmd_done_r;
  logic [1:0] dummy_cnt_r;
  logic quad_r;
  logic [3:0] step;
  assign step = quad_r ? 4'd4 : 4'd1;
  // Mode latched at frame start so lanes never change mid-frame
  always_ff @(posedge CLK_SYS or negedge rst_n_r)
  begin
    if (!rst_n_r)
      quad_r <= 1'b0;
    else if (cs_act && !cs_d_r)
      quad_r <= quad_s;
  end
  // Byte capture on rising SCK, then dummy clock count
  always_ff @(posedge CLK_SYS or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cmd_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      cmd_done_r <= 1'b0;
      dummy_cnt_r <= 2'd0;
    end
    else if (!cs_act)
    begin
      bit_cnt_r <= 4'h0;
      cmd_done_r <= 1'b0;
      dummy_cnt_r <= 2'd0;
    end
    else if (sck_rise)
    begin
      if (!cmd_done_r)
      begin
        cmd_r <= shift_in(cmd_r, sio_s, quad_r);
        bit_cnt_r <= bit_cnt_r + step;
        if (bit_cnt_r + step == 4'd8)
          cmd_done_r <= 1'b1;
      end
      else if (dummy_cnt_r != 2'(DUMMY_CLOCKS))
        dummy_cnt_r <= dummy_cnt_r + 2'd1;
    end
  end
  logic is_release, is_entry;
  assign is_release = cmd_done_r && cmd_r == RELEASE_POWER_DOWN_CMD;
  assign is_entry = cmd_done_r && cmd_r == DEEP_SLEEP_ENTRY_CMD;
  // ==========================================================
  // Power state machine
  dpr_pwr_t pwr_r;
  logic [CNT_W-1:0] tmr_r;
  logic release_frame, entry_frame;
  assign release_frame = cs_rise_end && is_release;
  // Entry while writing is dropped; must not strand a busy array
  assign entry_frame = cs_rise_end && is_entry && !WRITE_BUSY;
  always_ff @(posedge CLK_SYS or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pwr_r <= PWR_STANDBY;
      tmr_r <= '0;
    end
    else
    begin
      case (pwr_r)
        PWR_STANDBY:
        begin
          if (entry_frame)
          begin
            pwr_r <= PWR_ENTERING;
            // Sync stages and edge detect already used part of the budget
            tmr_r <= CNT_W'(SLEEP_ENTRY_CYC - SAMPLE_STAGES - 2);
          end
        end
        PWR_ENTERING:
        begin
          if (tmr_r == '0)
            pwr_r <= PWR_DEEP;
          else
            tmr_r <= tmr_r - 1'b1;
        end
        PWR_DEEP:
        begin
          // Only the release byte is decoded here
          if (release_frame)
          begin
            pwr_r <= PWR_WAKING;
            // Budget counts from the pin edge, not from its detection
            tmr_r <= CNT_W'(STANDBY_RECOVERY_CYC - SAMPLE_STAGES - 2);
          end
        end
        PWR_WAKING:
        begin
          if (tmr_r == '0)
            pwr_r <= PWR_STANDBY;
          else
            tmr_r <= tmr_r - 1'b1;
        end
        default:
          pwr_r <= PWR_STANDBY;
      endcase
    end
  end
  assign DEEP_SLEEP = pwr_r == PWR_DEEP;
  assign READY = pwr_r == PWR_STANDBY;
  // ==========================================================
  // ID output, shifted on falling SCK after the dummy clocks
  logic [ID_BITS-1:0] id_sh_r;
  logic [3:0] out_r;
  logic drive_r;
  always_ff @(posedge CLK_SYS or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      id_sh_r <= DEVICE_ID_RST;
      out_r <= 4'h0;
      drive_r <= 1'b0;
    end
    else if (!cs_act)
    begin
      id_sh_r <= DEVICE_ID_RST;
      drive_r <= 1'b0;
    end
    else if (sck_fall && is_release && pwr_r == PWR_DEEP
             && dummy_cnt_r == 2'(DUMMY_CLOCKS))
    begin
      // Wraps the ID so the stream never stalls
      drive_r <= 1'b1;
      if (quad_r)
      begin
        out_r <= id_sh_r[ID_BITS-1 -: 4];
        id_sh_r <= {id_sh_r[ID_BITS-5:0], id_sh_r[ID_BITS-1 -: 4]};
      end
      else
      begin
        out_r <= {3'b000, id_sh_r[ID_BITS-1]};
        id_sh_r <= {id_sh_r[ID_BITS-2:0], id_sh_r[ID_BITS-1]};
      end
    end
  end
  assign SIO_OUT = quad_r ? out_r : {2'b00, out_r[0], 1'b0};
  assign SIO_OE_N = !drive_r ? 4'hF : (quad_r ? 4'h0 : 4'hD);
  // ==========================================================
  // Checks
  AST_ENTRY_BOUND: assert property (@(posedge CLK_SYS) disable iff (!rst_n_r)
    pwr_r == PWR_STANDBY && entry_frame |-> ##[1:120] DEEP_SLEEP)
    else $error("deep sleep not reached in time");
  AST_WAKE_BOUND: assert property (@(posedge CLK_SYS) disable iff (!rst_n_r)
    DEEP_SLEEP && release_frame |-> ##[1:400] READY)
    else $error("standby not reached in time");
  AST_RELEASE_LEAVES: assert property (@(posedge CLK_SYS)
    disable iff (!rst_n_r)
    DEEP_SLEEP && release_frame |=> pwr_r == PWR_WAKING)
    else $error("release ignored");
  AST_DEEP_HOLDS: assert property (@(posedge CLK_SYS) disable iff (!rst_n_r)
    DEEP_SLEEP && !release_frame |=> DEEP_SLEEP)
    else $error("deep sleep left without release");
  AST_BUSY_BLOCKS: assert property (@(posedge CLK_SYS) disable iff (!rst_n_r)
    READY && WRITE_BUSY |=> !DEEP_SLEEP && pwr_r != PWR_ENTERING)
    else $error("entry taken while busy");
  AST_ENTRY_AT_CS: assert property (@(posedge CLK_SYS) disable iff (!rst_n_r)
    $rose(pwr_r == PWR_ENTERING) |-> $past(cs_rise_end))
    else $error("entry without chip select rise");
  AST_DRIVE_ONLY_SELECTED: assert property (@(posedge CLK_SYS)
    disable iff (!rst_n_r)
    !cs_act |=> SIO_OE_N == 4'hF)
    else $error("lanes driven after deselect");
  AST_DRIVE_AFTER_DUMMY: assert property (@(posedge CLK_SYS)
    disable iff (!rst_n_r)
    $rose(drive_r) |-> $past(sck_fall) && $past(dummy_cnt_r) == 2'd3)
    else $error("ID driven before dummy clocks");
  AST_QUAD_LANES: assert property (@(posedge CLK_SYS) disable iff (!rst_n_r)
    drive_r && quad_r |-> SIO_OE_N == 4'h0)
    else $error("quad mode not using four lanes");
  COV_ENTRY: cover property (@(posedge CLK_SYS) $rose(DEEP_SLEEP));
  COV_WAKE: cover property (@(posedge CLK_SYS) $rose(READY));
  COV_ID: cover property (@(posedge CLK_SYS) $rose(drive_r));
endmodule

//--- dv/dpr_host_model.sv
// Host controller model driving the serial command link.
// Assumes clk is the system clock; link edges sit 2 ns after it.
`timescale 1ns/1ps
module dpr_host_model (
  input wire logic clk, // System clock
  input wire logic [3:0] sio_pin, // Resolved lanes
  input wire logic [3:0] oe_n_pin, // Device lane enables
  output logic ce_n, // Chip select, active low
  output logic sck, // Serial clock, still between frames
  output logic [3:0] sio // Host lane drive
);
  // ==========================================
  // Link idle at time zero
  initial
  begin
    ce_n = 1'b1;
    sck = 1'b0;
    sio = 4'h0;
  end
  // Half of a 200 ns link period
  task automatic half();
    repeat (4) @(posedge clk);
    #2;
  endtask
  // ==========================================
  // Command alone, or command, three dummies and nrd read clocks
  task automatic frame(input logic [7:0] cmd, input logic quad,
    input int nrd, output logic [31:0] rd, output logic [3:0] oe);
    int nb;
    nb = quad ? 2 : 8;
    rd = 32'h0000_0000;
    oe = 4'hF;
    @(posedge clk);
    #2;
    ce_n = 1'b0;
    for (int i = 0; i < nb + (nrd > 0 ? 3 : 0) + nrd; i++)
    begin
      // Unused lanes toggle so a stale level never looks valid
      if (i < nb)
        sio = quad ? cmd[7-4*i -: 4] : {~sio[3:1], cmd[7-i]};
      else
        sio = ~sio;
      half();
      sck = 1'b1;
      if (i >= nb + 3)
      begin
        rd = quad ? {rd[27:0], sio_pin} : {rd[30:0], sio_pin[1]};
        oe = oe_n_pin;
      end
      half();
      sck = 1'b0;
    end
    half();
    ce_n = 1'b1;
    half();
  endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the deep power-down release logic.
// Assumes the host model drives the link; lanes resolved here.
`timescale 1ns/1ps
module testbench;
  import dpr_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic quad = 1'b0;
  logic busy = 1'b0;
  logic ce_n, sck, deep_sleep, ready;
  logic [3:0] host_sio, sio_in, sio_out, oe_n, oe;
  logic [31:0] rd;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Identity read wraps, so 32 bits end with its top byte again
  localparam logic [31:0] ID_WRAP =
    {DEVICE_ID_RST, DEVICE_ID_RST[ID_BITS-1 -: 8]};
  // ==========================================
  // Clock, lane resolution and instances
  initial forever #12.5 clk_sys = ~clk_sys;
  assign sio_in = (host_sio & oe_n) | (sio_out & ~oe_n);
  dpr_ctrl uut (.CLK_SYS(clk_sys), .RESETN(resetn), .CE_N(ce_n),
    .SCK(sck), .SIO_IN(sio_in), .SIO_OUT(sio_out), .SIO_OE_N(oe_n),
    .QUAD_LANE_SERIAL_MODE(quad), .WRITE_BUSY(busy),
    .DEEP_SLEEP(deep_sleep), .READY(ready));
  dpr_host_model host (.clk(clk_sys), .sio_pin(sio_in),
    .oe_n_pin(oe_n), .ce_n(ce_n), .sck(sck), .sio(host_sio));
  // ==========================================
  // Shared helpers
  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait; limit is what is left of the budget after the frame
  task automatic wait_flag(input logic want_ready, input int lim);
    int k;
    k = 0;
    while ((want_ready ? ready : deep_sleep) !== 1'b1 && k <= lim)
    begin
      step();
      k++;
    end
    chk(32'(k <= lim), 32'h1);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_busy();
    busy = 1'b1;
    host.frame(DEEP_SLEEP_ENTRY_CMD, 1'b0, 0, rd, oe);
    repeat (200) step();
    chk({ready, deep_sleep}, 2'b10);
    busy = 1'b0;
  endtask
  task automatic t_entry(input logic q);
    quad = q;
    host.frame(DEEP_SLEEP_ENTRY_CMD, q, 0, rd, oe);
    // Four cycles of the budget pass in the frame's closing half
    wait_flag(1'b0, SLEEP_ENTRY_CYC - 4);
    chk(ready, 1'b0);
  endtask
  task automatic t_ignore();
    host.frame(8'h9F, 1'b0, 0, rd, oe);
    repeat (500) step();
    chk({ready, deep_sleep}, 2'b01);
  endtask
  task automatic t_release(input logic q, input int nrd);
    quad = q;
    host.frame(RELEASE_POWER_DOWN_CMD, q, nrd, rd, oe);
    if (nrd > 0)
    begin
      chk(rd, ID_WRAP);
      chk(oe, q ? 4'h0 : 4'hD);
    end
    repeat (8) step();
    chk(oe_n, 4'hF);
    // Closing half plus eight steps already spent twelve cycles
    wait_flag(1'b1, STANDBY_RECOVERY_CYC - 12);
    chk(deep_sleep, 1'b0);
  endtask
  // Release while awake: no identity drive, stays ready
  task automatic t_awake();
    host.frame(RELEASE_POWER_DOWN_CMD, 1'b0, 8, rd, oe);
    chk({ready, oe}, 5'h1F);
  endtask
  // ==========================================
  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      final_report();
    end
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #2;
    resetn = 1'b1;
    repeat (8) step();
    chk({ready, deep_sleep, oe_n}, 6'h2F);
    t_busy();
    t_entry(1'b0);
    t_ignore();
    t_release(1'b0, 0);
    t_awake();
    t_entry(1'b1);
    t_release(1'b1, 8);
    t_entry(1'b0);
    t_release(1'b0, 32);
    final_report();
  end
endmodule
